// *** rtl/mfp2_pin_ctrl.sv ***
// Function selection and control of the second multi-function pin
//
// Summary of operation
// - Selector bits 7..4, zero disables pin.
// - Code 0010 outputs headset detect, active high.
// - Code 0011 is input, driver off.
// - Bit 2 reads sampled pin level.
// - Code 0100 is general-purpose output.
// - Bit 3 sets driven output level.
// - Codes 0101-0111 microphone data, both edges.
// - Code 1000 bit clock, direction from bus.
// - Code 1001 outputs headset OR button.
// - Code 1010 outputs OR of four sources.
// - Code 1101 outputs short-circuit only.
// - Duration bit 0 gives single 2 ms pulse.
// - Duration bit 1 repeats pulses until flags read.
`timescale 1ns/1ns
module mfp2_pin_ctrl
  import mfp2_pkg::*;
#(
  parameter int PULSE_CYC = MFP2_PULSE_CYC,
  parameter int GAP_CYC   = MFP2_GAP_CYC
) (
  input  wire logic      clk_sys,
  input  wire logic      reset,
  input  wire mfp2_wr_s  reg_wr,
  output logic [7:0]     reg_rdata,
  input  wire mfp2_irq_s irq_src,
  input  wire logic      flags_read,
  input  wire logic      bclk_out,
  input  wire logic      bclk_is_master,
  input  wire logic      dmic_clk,
  output logic [1:0]     dmic_data,
  output logic           dmic_valid,
  output logic           bclk_in,
  input  wire logic      pin_in,
  output logic           pin_out,
  output logic           pin_oe
);

  localparam int CNT_W = $clog2((PULSE_CYC > GAP_CYC ? PULSE_CYC : GAP_CYC) + 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST   = CNT_W'(GAP_CYC - 1);

  logic [3:0]       sel;
  logic             out_val;
  logic             dur_cont;
  logic             in_val;
  logic             irq_sel;
  logic             irq_sel_d;
  logic             irq_pending;
  logic             dmic_clk_d;
  logic             dmic_rise_seen;
  logic [CNT_W-1:0] cnt;
  mfp2_state_e      state;
  logic             next_pin_out;
  logic             next_pin_oe;

  // Selected interrupt source for a selector code
  function automatic logic sel_irq(input logic [3:0] code, input mfp2_irq_s s);
    case (code)
      MFP2_SEL_JACK_INT:  sel_irq = s.headset;
      MFP2_SEL_HS_BTN:    sel_irq = s.headset | s.button;
      MFP2_SEL_ALL4:      sel_irq = s.headset | s.button | s.short_circuit | s.level_noise;
      MFP2_SEL_SC_ALC:    sel_irq = s.short_circuit | s.level_noise;
      MFP2_SEL_HS_BTN_SC: sel_irq = s.headset | s.button | s.short_circuit;
      MFP2_SEL_SC:        sel_irq = s.short_circuit;
      MFP2_SEL_ALC:       sel_irq = s.level_noise;
      MFP2_SEL_BTN:       sel_irq = s.button;
      default:            sel_irq = 1'b0;
    endcase
  endfunction

  // True when the code routes an interrupt to the pin
  function automatic logic is_irq_code(input logic [3:0] code);
    is_irq_code = (code == MFP2_SEL_JACK_INT) || (code >= MFP2_SEL_HS_BTN);
  endfunction

  // Control register writes; reserved bit is never stored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sel      <= MFP2_SEL_RESET;
      out_val  <= MFP2_BIT_RESET;
      dur_cont <= MFP2_BIT_RESET;
    end else if (reg_wr.wr && reg_wr.addr == MFP2_REG_OFFSET) begin
      sel      <= reg_wr.data[MFP2_SEL_MSB:MFP2_SEL_LSB];
      out_val  <= reg_wr.data[MFP2_OUT_VAL_BIT];
      dur_cont <= reg_wr.data[MFP2_DUR_BIT];
    end
  end

  // Sampled pin level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in_val <= MFP2_BIT_RESET;
    end else begin
      in_val <= pin_in;
    end
  end

  // Read-back with reserved bit held at zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= {sel, out_val, in_val, dur_cont, 1'b0};
    end
  end

  // Interrupt edge capture, held until flags are read only while the duration bit is set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_sel     <= 1'b0;
      irq_sel_d   <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      irq_sel   <= sel_irq(sel, irq_src);
      irq_sel_d <= irq_sel;
      if (irq_sel && !irq_sel_d) begin
        irq_pending <= 1'b1; // New event wins over a flags read
      end else if (!dur_cont || flags_read || !is_irq_code(sel)) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // Pulse generator: one pulse, or a train until flags are read
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= MFP2_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        MFP2_IDLE: begin
          cnt <= '0;
          if (irq_sel && !irq_sel_d && is_irq_code(sel)) begin
            state <= MFP2_PULSE;
          end
        end
        MFP2_PULSE: begin
          if (cnt == PULSE_LAST) begin
            cnt   <= '0;
            state <= MFP2_GAP;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        MFP2_GAP: begin
          if (cnt == GAP_LAST) begin
            cnt   <= '0;
            state <= (dur_cont && irq_pending) ? MFP2_PULSE : MFP2_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          state <= MFP2_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // Pin drive selection
  always_comb begin
    next_pin_out = 1'b0;
    next_pin_oe  = 1'b0;
    if (sel == MFP2_SEL_GP_OUT) begin
      next_pin_out = out_val;
      next_pin_oe  = 1'b1;
    end else if (sel == MFP2_SEL_BCLK) begin
      next_pin_out = bclk_out;
      next_pin_oe  = bclk_is_master;
    end else if (is_irq_code(sel)) begin
      next_pin_out = (state == MFP2_PULSE);
      next_pin_oe  = 1'b1;
    end
    // Disabled, reserved, input and microphone codes leave the pin undriven
  end

  // Registered pin outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  // Bit clock input path when the serial bus is a slave
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bclk_in <= 1'b0;
    end else begin
      bclk_in <= (sel == MFP2_SEL_BCLK) && !bclk_is_master && pin_in;
    end
  end

  // Microphone data taken on both clock edges, delivered as a pair
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dmic_clk_d     <= 1'b0;
      dmic_rise_seen <= 1'b0;
      dmic_data      <= 2'h0;
      dmic_valid     <= 1'b0;
    end else begin
      dmic_clk_d <= dmic_clk;
      dmic_valid <= 1'b0;
      if (sel >= MFP2_SEL_DMIC_LO && sel <= MFP2_SEL_DMIC_HI) begin
        if (dmic_clk && !dmic_clk_d) begin
          dmic_data[1]   <= pin_in;
          dmic_rise_seen <= 1'b1;
        end else if (!dmic_clk && dmic_clk_d && dmic_rise_seen) begin
          dmic_data[0]   <= pin_in;
          dmic_valid     <= 1'b1;
          dmic_rise_seen <= 1'b0;
        end
      end else begin
        dmic_rise_seen <= 1'b0;
      end
    end
  end

  // Pin is never driven while disabled or input
  property p_undriven_modes;
    @(posedge clk_sys) disable iff (reset)
    (sel == MFP2_SEL_DISABLED || sel == MFP2_SEL_GP_IN) |=> !pin_oe;
  endproperty
  a_undriven_modes: assert property (p_undriven_modes)
    else $error("pin driven in undriven mode");

  property p_disabled_low;
    @(posedge clk_sys) disable iff (reset)
    sel == MFP2_SEL_DISABLED |=> !pin_out && !pin_oe;
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("disabled pin active");

  property p_gp_out;
    @(posedge clk_sys) disable iff (reset)
    sel == MFP2_SEL_GP_OUT |=> pin_oe && pin_out == $past(out_val);
  endproperty
  a_gp_out: assert property (p_gp_out)
    else $error("output level mismatch");

  property p_in_readback;
    @(posedge clk_sys) disable iff (reset)
    1'b1 |-> ##2 reg_rdata[MFP2_IN_VAL_BIT] == $past(pin_in, 2);
  endproperty
  a_in_readback: assert property (p_in_readback)
    else $error("input readback wrong");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (reset)
    1'b1 |-> !reg_rdata[MFP2_RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit reads one");

  property p_pulse_starts;
    @(posedge clk_sys) disable iff (reset)
    (state == MFP2_IDLE && irq_sel && !irq_sel_d && is_irq_code(sel)) |=> state == MFP2_PULSE;
  endproperty
  a_pulse_starts: assert property (p_pulse_starts)
    else $error("interrupt pulse not started");

  property p_single_ends;
    @(posedge clk_sys) disable iff (reset)
    (state == MFP2_GAP && cnt == GAP_LAST && !dur_cont) |=> state == MFP2_IDLE;
  endproperty
  a_single_ends: assert property (p_single_ends)
    else $error("single pulse repeated");

  property p_train_repeats;
    @(posedge clk_sys) disable iff (reset)
    (state == MFP2_GAP && cnt == GAP_LAST && dur_cont && irq_pending) |=> state == MFP2_PULSE;
  endproperty
  a_train_repeats: assert property (p_train_repeats)
    else $error("pulse train stopped early");

  property p_sc_only;
    @(posedge clk_sys) disable iff (reset)
    sel == MFP2_SEL_SC && $stable(sel) |=> irq_sel == $past(irq_src.short_circuit);
  endproperty
  a_sc_only: assert property (p_sc_only)
    else $error("short-circuit routing wrong");

  // Bit clock pin drives only while the serial bus is master
  property p_bclk_dir;
    @(posedge clk_sys) disable iff (reset)
    sel == MFP2_SEL_BCLK |=> pin_oe == $past(bclk_is_master);
  endproperty
  a_bclk_dir: assert property (p_bclk_dir)
    else $error("bit clock direction wrong");

  c_gp_out:  cover property (@(posedge clk_sys) disable iff (reset) sel == MFP2_SEL_GP_OUT && pin_out);
  c_pulse:   cover property (@(posedge clk_sys) disable iff (reset) state == MFP2_PULSE);
  c_train:   cover property (@(posedge clk_sys) disable iff (reset)
                             state == MFP2_GAP ##1 state == MFP2_PULSE);
  c_dmic:    cover property (@(posedge clk_sys) disable iff (reset) dmic_valid);

endmodule

// *** rtl/mfp2_pkg.sv ***
// Package: register map, field layout, selector codes and timing for pin two control
package mfp2_pkg;

  // Register location and field positions
  localparam logic [7:0] MFP2_REG_OFFSET     = 8'h63;
  localparam int         MFP2_SEL_MSB        = 7;
  localparam int         MFP2_SEL_LSB        = 4;
  localparam int         MFP2_OUT_VAL_BIT    = 3;
  localparam int         MFP2_IN_VAL_BIT     = 2;
  localparam int         MFP2_DUR_BIT        = 1;
  localparam int         MFP2_RSVD_BIT       = 0;

  // Reset values
  localparam logic [3:0] MFP2_SEL_RESET      = 4'h0;
  localparam logic       MFP2_BIT_RESET      = 1'b0;

  // Selector codes
  localparam logic [3:0] MFP2_SEL_DISABLED   = 4'h0;
  localparam logic [3:0] MFP2_SEL_RESERVED   = 4'h1;
  localparam logic [3:0] MFP2_SEL_JACK_INT   = 4'h2;
  localparam logic [3:0] MFP2_SEL_GP_IN      = 4'h3;
  localparam logic [3:0] MFP2_SEL_GP_OUT     = 4'h4;
  localparam logic [3:0] MFP2_SEL_DMIC_LO    = 4'h5;
  localparam logic [3:0] MFP2_SEL_DMIC_HI    = 4'h7;
  localparam logic [3:0] MFP2_SEL_BCLK       = 4'h8;
  localparam logic [3:0] MFP2_SEL_HS_BTN     = 4'h9;
  localparam logic [3:0] MFP2_SEL_ALL4       = 4'ha;
  localparam logic [3:0] MFP2_SEL_SC_ALC     = 4'hb;
  localparam logic [3:0] MFP2_SEL_HS_BTN_SC  = 4'hc;
  localparam logic [3:0] MFP2_SEL_SC         = 4'hd;
  localparam logic [3:0] MFP2_SEL_ALC        = 4'he;
  localparam logic [3:0] MFP2_SEL_BTN        = 4'hf;

  // Timing
  localparam int         MFP2_CLK_MHZ        = 100;
  localparam int         MFP2_PULSE_US       = 2000;
  localparam int         MFP2_PULSE_CYC      = MFP2_PULSE_US * MFP2_CLK_MHZ;
  localparam int         MFP2_GAP_US         = 2000;
  localparam int         MFP2_GAP_CYC        = MFP2_GAP_US * MFP2_CLK_MHZ;

  // Interrupt sources
  typedef struct packed {
    logic headset;
    logic button;
    logic short_circuit;
    logic level_noise;
  } mfp2_irq_s;

  // Register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } mfp2_wr_s;

  typedef enum logic [1:0] {
    MFP2_IDLE,
    MFP2_PULSE,
    MFP2_GAP
  } mfp2_state_e;

endpackage

// *** tb/mfp2_pin_model.sv ***
// External circuit on the second multi-function pin
`timescale 1ns/1ns
module mfp2_pin_model (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic ext_lvl,
  output logic      pin_in
);
  // The pin follows the block's driver while enabled, else the outside level
  assign pin_in = pin_oe ? pin_out : ext_lvl;
endmodule

// *** tb/mfp2_pin_ctrl_test.sv ***
// Register-level tests of the second multi-function pin control
`timescale 1ns/1ns
module mfp2_pin_ctrl_test;
  import mfp2_pkg::*;
  localparam int PULSE = 8;
  localparam int GAP   = 4;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  mfp2_wr_s   reg_wr = '0;
  logic [7:0] reg_rdata;
  mfp2_irq_s  irq_src = '0;
  logic       flags_read = 1'b0;
  logic       bclk_out = 1'b0;
  logic       bclk_is_master = 1'b0;
  logic       dmic_clk = 1'b0;
  logic [1:0] dmic_data;
  logic       dmic_valid, bclk_in, pin_in, pin_out, pin_oe;
  logic       ext_lvl = 1'b0;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         n;
  // Interrupt codes and their sources {headset, button, short, noise}
  logic [3:0] codes [8] = '{4'h2, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  logic [3:0] masks [8] = '{4'h8, 4'hc, 4'hf, 4'h3, 4'he, 4'h2, 4'h1, 4'h4};

  always #5 clk_sys = ~clk_sys;

  mfp2_pin_ctrl #(.PULSE_CYC(PULSE), .GAP_CYC(GAP)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .irq_src(irq_src), .flags_read(flags_read), .bclk_out(bclk_out),
    .bclk_is_master(bclk_is_master), .dmic_clk(dmic_clk), .dmic_data(dmic_data),
    .dmic_valid(dmic_valid), .bclk_in(bclk_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));

  mfp2_pin_model pin_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_in(pin_in));

  // Verdict and end of run
  task close_out;
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register write, then wait for the readback to settle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= '{1'b1, a, d};
    @(posedge clk_sys);
    reg_wr.wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  // Counts cycles with the pin output high
  task count_hi(input int span, output int hi);
    hi = 0;
    repeat (span) begin
      @(posedge clk_sys);
      #1;
      hi += (pin_out === 1'b1);
    end
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    num_errors++;
    close_out();
  end

  initial begin
    cyc(15);
    chk(reg_rdata, 8'h00);
    chk(8'(pin_oe), 8'h00);
    @(posedge clk_sys);
    reset <= 1'b0;
    // General-purpose output, both levels; reserved code 0001 never written
    wr(8'h63, 8'h48);
    chk(reg_rdata, 8'h4c);
    chk(8'(pin_oe), 8'h01);
    wr(8'h63, 8'h40);
    chk(8'(pin_out), 8'h00);
    wr(8'h62, 8'hff);
    chk(reg_rdata, 8'h40);
    // Input with duration bit set; reserved bit left clear and read as zero
    @(posedge clk_sys);
    ext_lvl <= 1'b1;
    wr(8'h63, 8'h3a);
    chk(reg_rdata, 8'h3e);
    chk(8'(pin_oe), 8'h00);
    @(posedge clk_sys);
    ext_lvl <= 1'b0;
    cyc(3);
    chk(reg_rdata, 8'h3a);
    // Every interrupt code against every single source, single pulses
    for (int c = 0; c < 8; c++) begin
      wr(8'h63, {codes[c], 4'h0});
      chk(8'(pin_oe), 8'h01);
      for (int s = 0; s < 4; s++) begin
        @(posedge clk_sys);
        irq_src <= 4'(1 << s);
        count_hi(30, n);
        chk(8'(n), masks[c][s] ? 8'(PULSE) : 8'h00);
        @(posedge clk_sys);
        irq_src <= '0;
        cyc(4);
      end
    end
    // Continuous pulses until the flags are read
    wr(8'h63, 8'h22);
    @(posedge clk_sys);
    irq_src <= 4'h8;
    count_hi(40, n);
    chk(8'(n >= 2 * PULSE), 8'h01);
    @(posedge clk_sys);
    flags_read <= 1'b1;
    irq_src <= '0;
    @(posedge clk_sys);
    flags_read <= 1'b0;
    cyc(20);
    count_hi(30, n);
    chk(8'(n), 8'h00);
    // Bit clock, driven as master and taken in as slave
    @(posedge clk_sys);
    bclk_is_master <= 1'b1;
    bclk_out <= 1'b1;
    wr(8'h63, 8'h80);
    chk({6'h0, pin_oe, pin_out}, 8'h03);
    @(posedge clk_sys);
    bclk_is_master <= 1'b0;
    ext_lvl <= 1'b1;
    cyc(3);
    chk({6'h0, pin_oe, bclk_in}, 8'h01);
    @(posedge clk_sys);
    ext_lvl <= 1'b0;
    cyc(3);
    chk(8'(bclk_in), 8'h00);
    // Microphone data on both clock edges, every code of the range
    for (int c = 5; c < 8; c++) begin
      wr(8'h63, {4'(c), 4'h0});
      @(posedge clk_sys);
      dmic_clk <= 1'b1;
      ext_lvl <= c[0];
      cyc(4);
      @(posedge clk_sys);
      dmic_clk <= 1'b0;
      ext_lvl <= ~c[0];
      n = 0;
      while (dmic_valid !== 1'b1 && n < 10) begin
        cyc(1);
        n++;
      end
      chk({5'h0, dmic_valid, dmic_data}, {5'h0, 1'b1, c[0], ~c[0]});
    end
    // Selector zero returns the pin to idle
    wr(8'h63, 8'h00);
    chk(8'(pin_oe), 8'h00);
    close_out();
  end
endmodule
